//--- design/rsi_regs.svh
/*
 rsi_regs.svh: register indices, field positions, init values and cause masks
 of the reset state initializer. Assumes a word-per-register AXI4-Lite map.
*/
// How it works
// (RULE1) Five reset causes are told apart and each register applies its own policy for the active cause.
// (RULE2) Every cause loads both multi-function timer free-running counters with one.
// (RULE3) Every cause clears both timers' compare and capture registers.
// (RULE4) Every cause clears both timers' control registers.
// (RULE5) SRAM file registers are left alone on power-on or brown-out and keep their contents otherwise.
// (RULE6) A watchdog reset gives timeout/power-down flags 00 in power-down mode and 01 in active mode.
// (RULE7) An external clear in power-down mode gives timeout/power-down flags 10.
// (RULE8) An external clear in active mode leaves the timeout/power-down flags as they were.
// (RULE9) Every cause sets option, port direction and port configuration to ones, mode to 1f, pc low to ff.
// (RULE10) Every cause sets comparator bits 0,6,7, clears status bits 5-7, and sets pointer bit 7 except on power-on.
`ifndef RSI_REGS_SVH
`define RSI_REGS_SVH

`define RSI_IX_HI 9
`define RSI_IX_LO 2
`define RSI_AW 12
`define RSI_NCAUSE 5

`define RSI_IX_REALTIME_COUNTER 8'h01
`define RSI_IX_PCL 8'h02
`define RSI_IX_STATUS 8'h03
`define RSI_IX_FSR 8'h04
`define RSI_IX_W 8'h0f
`define RSI_IX_OPTION 8'h10
`define RSI_IX_MODE 8'h11
`define RSI_IX_CMP 8'h12
`define RSI_IX_WKED 8'h13
`define RSI_IX_WKEN 8'h14
`define RSI_IX_WKPND 8'h15
`define RSI_IX_DIR 8'h18
`define RSI_IX_DATA 8'h20
`define RSI_IX_ST 8'h28
`define RSI_IX_LVL 8'h30
`define RSI_IX_PLP 8'h38
`define RSI_IX_TMR 8'h40
`define RSI_T_STRIDE 4
`define RSI_TF_CNT 0
`define RSI_TF_CTL 3
`define RSI_IX_IRQ_STAT 8'h60
`define RSI_IX_IRQ_EN 8'h61
`define RSI_IX_IRQ_CLR 8'h62
`define RSI_IX_CTRL 8'h63
`define RSI_IX_CAUSE 8'h64
`define RSI_IX_SRAM 8'h80

`define RSI_ZERO8 8'h00
`define RSI_ONES8 8'hff
`define RSI_PCL_INIT 8'hff
`define RSI_MODE_INIT 8'h1f
`define RSI_CMP_INIT 8'hc1
`define RSI_CMP_BITS 8'hc1
`define RSI_FSR_INIT 8'h80
`define RSI_FSR_BITS 8'h80
`define RSI_CNT_INIT 16'h0001
`define RSI_CMPCAP_INIT 16'h0000
`define RSI_TCTL_INIT 8'h00

`define RSI_ST_PD 3
`define RSI_ST_TO 4
`define RSI_ST_PAGE_MASK 8'he0
`define RSI_ST_SW_MASK 8'he7
`define RSI_STATUS_RST 8'h18
`define RSI_TOPD_TO 1
`define RSI_TOPD_PD 0
`define RSI_TOPD_POR 2'h3
`define RSI_TOPD_WDT_PD 2'h0
`define RSI_TOPD_WDT_ACT 2'h1
`define RSI_TOPD_XCLR_PD 2'h2
`define RSI_CTRL_PD 0

`define RSI_CAUSE_ALL 5'h1f
`define RSI_CAUSE_NOT_POR 5'h1e
`define RSI_CAUSE_NONE 5'h00
`define RSI_RESP_OK 2'h0
`define RSI_RESP_ERR 2'h2

`endif

//--- design/rsi_pkg.sv
/*
 rsi_pkg.sv: types of the reset state initializer.
 Assumes nothing of its surroundings.
*/
package rsi_pkg;
   // one bit per reset cause, por in bit 0
   typedef struct packed {
      logic xclr;
      logic wdt;
      logic bor;
      logic wake;
      logic por;
   } rsi_cause_type;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_APPLY = 3'h2,
      ST_DONE = 3'h4
   } rsi_state_type;
endpackage

//--- design/rsi_cell.sv
/*
 rsi_cell.sv: one register with a per-cause init policy and masked writes.
 Assumes load is a one-cycle pulse and cause is stable while it is high.
*/
`timescale 1ns/1ps
`include "rsi_regs.svh"

module rsi_cell
   import rsi_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] INIT = '0,
   parameter logic [WIDTH-1:0] BITS = '1,
   parameter logic [4:0] CAUSES = 5'h1f
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // cause load
   input wire logic load,
   input wire rsi_cause_type cause,
   // software write
   input wire logic wr_en,
   input wire logic [WIDTH-1:0] wr_mask,
   input wire logic [WIDTH-1:0] wr_data,
   // contents
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] q_r;
   logic [WIDTH-1:0] q_nxt;
   logic hit;

   assign hit = load && ((5'(cause) & CAUSES) != `RSI_CAUSE_NONE); // RULE1

   always_comb begin
      q_nxt = q_r;
      if (wr_en) begin
         q_nxt = (q_r & ~wr_mask) | (wr_data & wr_mask);
      end
      // cause load wins over a write in the same cycle
      if (hit) begin
         q_nxt = (q_nxt & ~BITS) | (INIT & BITS);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         q_r <= INIT;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign q = q_r;
endmodule

//--- design/rsi_top.sv
/*
 rsi_top.sv: reset state initializer and its AXI4-Lite register bank.
 Assumes the reset controller offers one cause at a time after nrst is
 released and that the core is stalled while core_hold is high.
*/
`timescale 1ns/1ps
`include "rsi_regs.svh"

module rsi_top
   import rsi_pkg::*;
#(
   parameter int NPORT = 5,
   parameter int NTIMER = 2,
   parameter int SRAM_DEPTH = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // axi4-lite write address and data
   input wire logic [`RSI_AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // axi4-lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read
   input wire logic [`RSI_AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // reset controller
   input wire logic init_valid,
   input wire rsi_cause_type init_cause,
   output logic init_ready,
   output logic init_done,
   output logic core_hold,
   // status
   output logic power_down,
   output logic timeout_flag,
   output logic power_down_flag,
   output logic irq
);
   localparam int NSING = 10;
   localparam int NGRP = 5;
   localparam int NTF = 3;
   localparam logic [7:0] SING_IX [NSING] = '{`RSI_IX_W, `RSI_IX_REALTIME_COUNTER, `RSI_IX_PCL, `RSI_IX_FSR,
      `RSI_IX_OPTION, `RSI_IX_MODE, `RSI_IX_CMP, `RSI_IX_WKED, `RSI_IX_WKEN, `RSI_IX_WKPND};
   localparam logic [7:0] SING_INIT [NSING] = '{`RSI_ZERO8, `RSI_ZERO8, `RSI_PCL_INIT, `RSI_FSR_INIT,
      `RSI_ONES8, `RSI_MODE_INIT, `RSI_CMP_INIT, `RSI_ONES8, `RSI_ONES8, `RSI_ZERO8};
   localparam logic [7:0] SING_BITS [NSING] = '{`RSI_ZERO8, `RSI_ZERO8, `RSI_ONES8, `RSI_FSR_BITS,
      `RSI_ONES8, `RSI_ONES8, `RSI_CMP_BITS, `RSI_ONES8, `RSI_ONES8, `RSI_ZERO8};
   localparam logic [4:0] SING_CAUSE [NSING] = '{`RSI_CAUSE_NONE, `RSI_CAUSE_NONE, `RSI_CAUSE_ALL,
      `RSI_CAUSE_NOT_POR, `RSI_CAUSE_ALL, `RSI_CAUSE_ALL, `RSI_CAUSE_ALL, `RSI_CAUSE_ALL,
      `RSI_CAUSE_ALL, `RSI_CAUSE_NONE};
   // port groups: direction, data, input level, level select, pull-up
   localparam logic [7:0] GRP_IX [NGRP] = '{`RSI_IX_DIR, `RSI_IX_DATA, `RSI_IX_ST, `RSI_IX_LVL, `RSI_IX_PLP};
   localparam logic [4:0] GRP_CAUSE [NGRP] = '{`RSI_CAUSE_ALL, `RSI_CAUSE_NONE, `RSI_CAUSE_ALL,
      `RSI_CAUSE_ALL, `RSI_CAUSE_ALL};

   rsi_state_type state_r;
   rsi_state_type state_nxt;
   rsi_cause_type cause_r;
   logic apply;
   logic aw_got_r;
   logic w_got_r;
   logic bvalid_r;
   logic rvalid_r;
   logic [1:0] bresp_r;
   logic [1:0] rresp_r;
   logic [7:0] awidx_r;
   logic [7:0] ridx;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic [31:0] rdata_r;
   logic [31:0] rd_val;
   logic wr_fire;
   logic [7:0] mask8;
   logic [15:0] mask16;
   logic [7:0] sq [NSING];
   logic [7:0] pq [NGRP][NPORT];
   logic [7:0] mq [SRAM_DEPTH];
   logic [15:0] tq [NTIMER][NTF];
   logic [7:0] tcq [NTIMER];
   logic [7:0] status_r;
   logic [7:0] status_nxt;
   logic [1:0] topd_nxt;
   logic pd_mode_r;
   logic [`RSI_NCAUSE-1:0] irq_stat_r;
   logic [`RSI_NCAUSE-1:0] irq_en_r;
   logic [`RSI_NCAUSE-1:0] irq_set;
   logic [`RSI_NCAUSE-1:0] irq_clr;

   function automatic logic map_hit(input logic [7:0] idx);
      logic hit;
      hit = (idx == `RSI_IX_STATUS) || (idx == `RSI_IX_IRQ_STAT) || (idx == `RSI_IX_IRQ_EN) ||
         (idx == `RSI_IX_IRQ_CLR) || (idx == `RSI_IX_CTRL) || (idx == `RSI_IX_CAUSE);
      for (int k = 0; k < NSING; k++) begin
         hit = hit || (idx == SING_IX[k]);
      end
      for (int g = 0; g < NGRP; g++) begin
         hit = hit || (int'(idx) >= int'(GRP_IX[g]) && int'(idx) < int'(GRP_IX[g]) + NPORT);
      end
      hit = hit || (int'(idx) >= int'(`RSI_IX_TMR) && int'(idx) < int'(`RSI_IX_TMR) + NTIMER * `RSI_T_STRIDE);
      hit = hit || (int'(idx) >= int'(`RSI_IX_SRAM) && int'(idx) < int'(`RSI_IX_SRAM) + SRAM_DEPTH);
      return hit;
   endfunction

   // sequencer: capture cause, apply for one cycle, report done
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (init_valid) begin
               state_nxt = ST_APPLY;
            end
         end
         ST_APPLY: state_nxt = ST_DONE;
         ST_DONE: state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cause_r <= '0;
      end else if (init_valid && state_r == ST_IDLE) begin
         cause_r <= init_cause; // RULE1
      end
   end

   assign apply = (state_r == ST_APPLY);
   assign init_ready = (state_r == ST_IDLE);
   assign init_done = (state_r == ST_DONE);
   assign core_hold = (state_r != ST_IDLE);

   // write channel: address and data taken in either order
   assign awready = !aw_got_r;
   assign wready = !w_got_r;
   assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
   assign mask8 = {8{wstrb_r[0]}};
   assign mask16 = {{8{wstrb_r[1]}}, mask8};

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         aw_got_r <= 1'b0;
         awidx_r <= '0;
      end else if (awvalid && awready) begin
         aw_got_r <= 1'b1;
         awidx_r <= awaddr[`RSI_IX_HI:`RSI_IX_LO];
      end else if (wr_fire) begin
         aw_got_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         w_got_r <= 1'b0;
         wdata_r <= '0;
         wstrb_r <= '0;
      end else if (wvalid && wready) begin
         w_got_r <= 1'b1;
         wdata_r <= wdata;
         wstrb_r <= wstrb;
      end else if (wr_fire) begin
         w_got_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bvalid_r <= 1'b0;
         bresp_r <= `RSI_RESP_OK;
      end else if (wr_fire) begin
         bvalid_r <= 1'b1;
         bresp_r <= map_hit(awidx_r) ? `RSI_RESP_OK : `RSI_RESP_ERR;
      end else if (bready) begin
         bvalid_r <= 1'b0;
      end
   end

   assign bvalid = bvalid_r;
   assign bresp = bresp_r;

   // read channel
   assign ridx = araddr[`RSI_IX_HI:`RSI_IX_LO];
   assign arready = !rvalid_r;

   always_comb begin
      rd_val = '0;
      case (ridx)
         `RSI_IX_STATUS: rd_val[7:0] = status_r;
         `RSI_IX_IRQ_STAT: rd_val[`RSI_NCAUSE-1:0] = irq_stat_r;
         `RSI_IX_IRQ_EN: rd_val[`RSI_NCAUSE-1:0] = irq_en_r;
         `RSI_IX_CTRL: rd_val[`RSI_CTRL_PD] = pd_mode_r;
         `RSI_IX_CAUSE: rd_val[`RSI_NCAUSE-1:0] = cause_r;
         default: rd_val = '0;
      endcase
      for (int k = 0; k < NSING; k++) begin
         if (ridx == SING_IX[k]) begin
            rd_val[7:0] = sq[k];
         end
      end
      for (int g = 0; g < NGRP; g++) begin
         for (int p = 0; p < NPORT; p++) begin
            if (ridx == 8'(int'(GRP_IX[g]) + p)) begin
               rd_val[7:0] = pq[g][p];
            end
         end
      end
      for (int t = 0; t < NTIMER; t++) begin
         for (int f = 0; f < NTF; f++) begin
            if (ridx == 8'(int'(`RSI_IX_TMR) + t * `RSI_T_STRIDE + f)) begin
               rd_val[15:0] = tq[t][f];
            end
         end
         if (ridx == 8'(int'(`RSI_IX_TMR) + t * `RSI_T_STRIDE + `RSI_TF_CTL)) begin
            rd_val[7:0] = tcq[t];
         end
      end
      for (int m = 0; m < SRAM_DEPTH; m++) begin
         if (ridx == 8'(int'(`RSI_IX_SRAM) + m)) begin
            rd_val[7:0] = mq[m];
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= `RSI_RESP_OK;
      end else if (arvalid && arready) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_val;
         rresp_r <= map_hit(ridx) ? `RSI_RESP_OK : `RSI_RESP_ERR;
      end else if (rready) begin
         rvalid_r <= 1'b0;
      end
   end

   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;

   // single registers: working reg, counter, pc low, pointer, option, mode, comparator, wake regs
   for (genvar k = 0; k < NSING; k++) begin : g_sing
      rsi_cell #(.WIDTH(8), .INIT(SING_INIT[k]), .BITS(SING_BITS[k]), .CAUSES(SING_CAUSE[k])) u_cell ( // RULE9 RULE10
         .clk(clk),
         .nrst(nrst),
         .load(apply),
         .cause(cause_r),
         .wr_en(wr_fire && awidx_r == SING_IX[k]),
         .wr_mask(mask8),
         .wr_data(wdata_r[7:0]),
         .q(sq[k])
      );
   end

   for (genvar g = 0; g < NGRP; g++) begin : g_grp
      for (genvar p = 0; p < NPORT; p++) begin : g_port
         rsi_cell #(.WIDTH(8), .INIT(`RSI_ONES8), .BITS(`RSI_ONES8), .CAUSES(GRP_CAUSE[g])) u_cell ( // RULE9
            .clk(clk),
            .nrst(nrst),
            .load(apply),
            .cause(cause_r),
            .wr_en(wr_fire && awidx_r == 8'(int'(GRP_IX[g]) + p)),
            .wr_mask(mask8),
            .wr_data(wdata_r[7:0]),
            .q(pq[g][p])
         );
      end
   end

   for (genvar t = 0; t < NTIMER; t++) begin : g_tmr
      for (genvar f = 0; f < NTF; f++) begin : g_fld
         rsi_cell #(
            .WIDTH(16),
            .INIT(f == `RSI_TF_CNT ? `RSI_CNT_INIT : `RSI_CMPCAP_INIT), // RULE2 RULE3
            .BITS(16'hffff),
            .CAUSES(`RSI_CAUSE_ALL)
         ) u_cell (
            .clk(clk),
            .nrst(nrst),
            .load(apply),
            .cause(cause_r),
            .wr_en(wr_fire && awidx_r == 8'(int'(`RSI_IX_TMR) + t * `RSI_T_STRIDE + f)),
            .wr_mask(mask16),
            .wr_data(wdata_r[15:0]),
            .q(tq[t][f])
         );
      end
      rsi_cell #(.WIDTH(8), .INIT(`RSI_TCTL_INIT), .BITS(`RSI_ONES8), .CAUSES(`RSI_CAUSE_ALL)) u_ctl ( // RULE4
         .clk(clk),
         .nrst(nrst),
         .load(apply),
         .cause(cause_r),
         .wr_en(wr_fire && awidx_r == 8'(int'(`RSI_IX_TMR) + t * `RSI_T_STRIDE + `RSI_TF_CTL)),
         .wr_mask(mask8),
         .wr_data(wdata_r[7:0]),
         .q(tcq[t])
      );
   end

   for (genvar m = 0; m < SRAM_DEPTH; m++) begin : g_sram
      rsi_cell #(.WIDTH(8), .INIT(`RSI_ZERO8), .BITS(`RSI_ZERO8), .CAUSES(`RSI_CAUSE_NONE)) u_cell ( // RULE5
         .clk(clk),
         .nrst(nrst),
         .load(apply),
         .cause(cause_r),
         .wr_en(wr_fire && awidx_r == 8'(int'(`RSI_IX_SRAM) + m)),
         .wr_mask(mask8),
         .wr_data(wdata_r[7:0]),
         .q(mq[m])
      );
   end

   // status: timeout/power-down from cause and mode, page bits cleared
   always_comb begin
      topd_nxt = {status_r[`RSI_ST_TO], status_r[`RSI_ST_PD]}; // RULE8
      if (cause_r.por) begin
         topd_nxt = `RSI_TOPD_POR;
      end else if (cause_r.wdt) begin
         topd_nxt = pd_mode_r ? `RSI_TOPD_WDT_PD : `RSI_TOPD_WDT_ACT; // RULE6
      end else if (cause_r.xclr && pd_mode_r) begin
         topd_nxt = `RSI_TOPD_XCLR_PD; // RULE7
      end
      status_nxt = status_r;
      if (apply) begin
         status_nxt = status_r & ~`RSI_ST_PAGE_MASK; // RULE10
         status_nxt[`RSI_ST_TO] = topd_nxt[`RSI_TOPD_TO];
         status_nxt[`RSI_ST_PD] = topd_nxt[`RSI_TOPD_PD];
      end else if (wr_fire && awidx_r == `RSI_IX_STATUS) begin
         status_nxt = (status_r & ~(mask8 & `RSI_ST_SW_MASK)) | (wdata_r[7:0] & mask8 & `RSI_ST_SW_MASK);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         status_r <= `RSI_STATUS_RST;
      end else begin
         status_r <= status_nxt;
      end
   end

   // power-down mode: entered by software, left on any cause
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pd_mode_r <= 1'b0;
      end else if (apply) begin
         pd_mode_r <= 1'b0;
      end else if (wr_fire && awidx_r == `RSI_IX_CTRL && wstrb_r[0]) begin
         pd_mode_r <= wdata_r[`RSI_CTRL_PD];
      end
   end

   // interrupts: sticky cause bits, set wins over clear
   assign irq_set = apply ? 5'(cause_r) : `RSI_CAUSE_NONE;
   assign irq_clr = (wr_fire && awidx_r == `RSI_IX_IRQ_CLR && wstrb_r[0]) ?
      wdata_r[`RSI_NCAUSE-1:0] : `RSI_CAUSE_NONE;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_stat_r <= `RSI_CAUSE_NONE;
      end else begin
         irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_en_r <= `RSI_CAUSE_NONE;
      end else if (wr_fire && awidx_r == `RSI_IX_IRQ_EN && wstrb_r[0]) begin
         irq_en_r <= wdata_r[`RSI_NCAUSE-1:0];
      end
   end

   assign irq = |(irq_stat_r & irq_en_r);
   assign power_down = pd_mode_r;
   assign timeout_flag = status_r[`RSI_ST_TO];
   assign power_down_flag = status_r[`RSI_ST_PD];
endmodule

//--- test/rsi_top_chk.sv
/*
 rsi_top_chk.sv: concurrent checks on the ports of the reset state initializer.
 Assumes one clock domain and the async active-low reset nrst; bound to rsi_top.
*/
`timescale 1ns/1ps

module rsi_top_chk
   import rsi_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // register bus
   input wire logic arready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   input wire logic rready,
   // reset controller
   input wire logic init_valid,
   input wire rsi_cause_type init_cause,
   input wire logic init_ready,
   input wire logic init_done,
   input wire logic core_hold,
   // status
   input wire logic power_down,
   input wire logic timeout_flag,
   input wire logic power_down_flag
);
   logic take;

   assign take = init_valid && init_ready;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   // apply cycle, then done cycle, then back to idle
   sequence apply_s;
      !init_ready && core_hold && !init_done ##1 init_done && core_hold ##1 init_ready && !core_hold && !init_done;
   endsequence

   init_seq_a: assert property (take |=> apply_s)
      else $error("cause handshake sequence wrong");
   wdt_pd_a: assert property (take && init_cause == 5'h08 && power_down |=> ##1 !timeout_flag && !power_down_flag)
      else $error("watchdog in power-down flags wrong");
   wdt_act_a: assert property (take && init_cause == 5'h08 && !power_down |=> ##1 !timeout_flag && power_down_flag)
      else $error("watchdog in active mode flags wrong");
   xclr_pd_a: assert property (take && init_cause == 5'h10 && power_down |=> ##1 timeout_flag && !power_down_flag)
      else $error("external clear in power-down flags wrong");
   xclr_keep_a: assert property (take && init_cause == 5'h10 && !power_down |=> ##1
         timeout_flag == $past(timeout_flag, 2) && power_down_flag == $past(power_down_flag, 2))
      else $error("external clear in active mode changed flags");
   por_flags_a: assert property (take && init_cause == 5'h01 |=> ##1 timeout_flag && power_down_flag)
      else $error("power-on flags wrong");
   pd_clear_a: assert property (take |=> ##1 !power_down)
      else $error("power-down mode not left on reset");
   bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped early");
   rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read data dropped early");
   ar_block_a: assert property (rvalid |-> !arready)
      else $error("read address taken while data pending");
endmodule

bind rsi_top rsi_top_chk chk_u (.clk, .nrst, .arready, .bresp, .bvalid, .bready, .rdata, .rresp, .rvalid,
   .rready, .init_valid, .init_cause, .init_ready, .init_done, .core_hold, .power_down, .timeout_flag,
   .power_down_flag);

//--- test/test_reset_state_initializer.sv
/*
 test_reset_state_initializer.sv: self-checking bench of the reset state initializer.
 Assumes rsi_top with default parameters and its checker bound beside it.
*/
`timescale 1ns/1ps
`include "rsi_regs.svh"

module test_reset_state_initializer;
   import rsi_pkg::*;
   logic clk = 1'h0;
   logic nrst = 1'h0;
   logic [`RSI_AW-1:0] awaddr = '0, araddr = '0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0, init_valid = 1'h0;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = 4'hf;
   rsi_cause_type init_cause = '0;
   logic awready, wready, bvalid, arready, rvalid, init_ready, init_done, core_hold;
   logic power_down, timeout_flag, power_down_flag, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int err_count = 0;
   int checked = 0;
   // registers that every cause initializes: index, checked bits, value
   localparam int NT = 20;
   localparam logic [7:0] TIX [NT] = '{`RSI_IX_OPTION, `RSI_IX_MODE, `RSI_IX_PCL, 8'h18, 8'h1c, 8'h2c, 8'h30, 8'h38,
      `RSI_IX_WKED, `RSI_IX_WKEN, `RSI_IX_CMP, `RSI_IX_STATUS, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47};
   localparam logic [15:0] TMK [NT] = '{16'hff, 16'hff, 16'hff, 16'hff, 16'hff, 16'hff, 16'hff, 16'hff, 16'hff,
      16'hff, 16'hc1, 16'he0, 16'hffff, 16'hffff, 16'hffff, 16'hff, 16'hffff, 16'hffff, 16'hffff, 16'hff};
   localparam logic [15:0] TEX [NT] = '{16'hff, 16'h1f, 16'hff, 16'hff, 16'hff, 16'hff, 16'hff, 16'hff, 16'hff,
      16'hff, 16'hc1, 16'h00, 16'h1, 16'h0, 16'h0, 16'h0, 16'h1, 16'h0, 16'h0, 16'h0};
   // flag steps: cause, power-down mode before it, expected timeout and power-down flags
   localparam logic [4:0] FC [7] = '{5'h08, 5'h08, 5'h10, 5'h10, 5'h01, 5'h10, 5'h02};
   localparam logic FP [7] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1};
   localparam logic [1:0] FE [7] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h3};

   rsi_top dut_u (.clk, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
      .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .init_valid, .init_cause,
      .init_ready, .init_done, .core_hold, .power_down, .timeout_flag, .power_down_flag, .irq);

   always #5 clk = ~clk;

   task automatic stop_test();
      $display("Mismatches: %0d, comparisons: %0d", err_count, checked);
      if (err_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] ix, input logic [31:0] d, input logic [1:0] er = `RSI_RESP_OK);
      logic ha, hw, hb;
      logic [1:0] r;
      int n;
      hb = 1'h0;
      n = 0;
      awaddr <= {2'h0, ix, 2'h0};
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (!hb && n < 40) begin
         @(negedge clk);
         ha = awvalid && awready;
         hw = wvalid && wready;
         hb = bvalid;
         r = bresp;
         @(posedge clk);
         if (ha)
            awvalid <= 1'h0;
         if (hw)
            wvalid <= 1'h0;
         n++;
      end
      cmp({hb, r}, {1'h1, er});
      bready <= 1'h0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] ix, input logic [31:0] m, input logic [31:0] e,
         input logic [1:0] er = `RSI_RESP_OK);
      logic ha, hr;
      logic [31:0] d;
      logic [1:0] r;
      int n;
      hr = 1'h0;
      n = 0;
      araddr <= {2'h0, ix, 2'h0};
      arvalid <= 1'h1;
      while (!hr && n < 40) begin
         @(negedge clk);
         ha = arvalid && arready;
         hr = rvalid && rready;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ha)
            arvalid <= 1'h0;
         if (n == 1)
            rready <= 1'h1;
         n++;
      end
      rready <= 1'h0;
      cmp({hr, r}, {1'h1, er});
      cmp(d & m, e);
      @(posedge clk);
   endtask

   // one cause request; returns at the edge that ends the done pulse
   task automatic go(input logic [4:0] c);
      logic ha, hd;
      int n;
      hd = 1'h0;
      n = 0;
      init_cause <= c;
      init_valid <= 1'h1;
      while (!hd && n < 20) begin
         @(negedge clk);
         ha = init_valid && init_ready;
         hd = init_done;
         @(posedge clk);
         if (ha)
            init_valid <= 1'h0;
         n++;
      end
      cmp(hd, 1'h1);
   endtask

   task automatic t_reset();
      for (int k = 0; k < NT; k++)
         rd(TIX[k], TMK[k], TEX[k]);
      rd(`RSI_IX_STATUS, 32'hff, `RSI_STATUS_RST);
      rd(`RSI_IX_FSR, 32'hff, `RSI_FSR_INIT);
   endtask

   task automatic t_causes();
      logic [4:0] c;
      for (int i = 0; i < `RSI_NCAUSE; i++) begin
         c = 5'h01 << i;
         for (int k = 0; k < NT; k++)
            wr(TIX[k], TEX[k] ^ TMK[k]);
         wr(`RSI_IX_SRAM, 32'ha5);
         wr(`RSI_IX_FSR, 32'h00);
         go(c);
         for (int k = 0; k < NT; k++)
            rd(TIX[k], TMK[k], TEX[k]);
         rd(`RSI_IX_CAUSE, 32'h1f, c);
         if (c != 5'h01 && c != 5'h04)
            rd(`RSI_IX_SRAM, 32'hff, 32'ha5);
         if (c != 5'h01)
            rd(`RSI_IX_FSR, 32'h80, 32'h80);
      end
   endtask

   task automatic t_flags();
      for (int i = 0; i < 7; i++) begin
         wr(`RSI_IX_CTRL, {31'h0, FP[i]});
         cmp(power_down, FP[i]);
         go(FC[i]);
         cmp({timeout_flag, power_down_flag, power_down}, {FE[i], 1'h0});
         rd(`RSI_IX_STATUS, 32'h18, {27'h0, FE[i], 3'h0});
      end
   endtask

   task automatic t_irq();
      wr(`RSI_IX_IRQ_CLR, 32'h1f);
      wr(`RSI_IX_IRQ_EN, 32'h08);
      go(5'h02);
      cmp(irq, 1'h0);
      rd(`RSI_IX_IRQ_STAT, 32'h1f, 32'h02);
      go(5'h08);
      cmp(irq, 1'h1);
      wr(`RSI_IX_IRQ_CLR, 32'h08);
      cmp(irq, 1'h0);
      rd(`RSI_IX_IRQ_STAT, 32'h1f, 32'h02);
      rd(`RSI_IX_IRQ_CLR, 32'h1f, 32'h00);
      rd(`RSI_IX_IRQ_EN, 32'h1f, 32'h08);
   endtask

   task automatic t_bus();
      wr(8'h70, 32'h0, `RSI_RESP_ERR);
      rd(8'h70, 32'hffffffff, 32'h0, `RSI_RESP_ERR);
      wr(`RSI_IX_STATUS, 32'h00);
      rd(`RSI_IX_STATUS, 32'h18, 32'h08);
      wr(`RSI_IX_CAUSE, 32'h1f);
      rd(`RSI_IX_CAUSE, 32'h1f, 32'h08);
   endtask

   initial begin
      repeat (10) @(posedge clk);
      nrst <= 1'h1;
      @(posedge clk);
      t_reset();
      t_causes();
      t_flags();
      t_irq();
      t_bus();
      stop_test();
   end

   initial begin
      #500000;
      err_count++;
      stop_test();
   end
endmodule
